// ### pkg/sgp_map.svh
// sgp_map.svh: offsets, field positions, reset values and codes of the segment-shared gpio port.
// assumes inclusion by bare name; definitions only.
// Summary of operation
// (R1) eight-bit output latch, bit n belongs to pin n.
// (R2) latch read returns stored bit where direction bit is 1.
// (R3) latch read returns sampled pin level where direction bit is 0.
// (R4) reset clears the output latch to 0x00.
// (R5) direction 1 drives latch value on pin, 0 makes pin an input.
// (R6) direction and latch act on a pin only in gpio selection.
// (R7) direction register is write-only and reads back all ones.
// (R8) reset clears all direction bits, every pin starts as input.
// (R9) select 00** gives gpio; 01** or 1*** drives segment n+17 instead.
// (R10) pins float during reset and during standby.
// (R11) sleep, subsleep, watch hold pins; active, subactive operate normally.
// (R12) latch writes land even on input pins, visible once switched to output.
`ifndef SGP_MAP_SVH
`define SGP_MAP_SVH

// register indices; byte address is four times the index
`define SGP_IDX_LATCH     16'hFFDA
`define SGP_IDX_DIR       16'hFFEA
`define SGP_IDX_STAT      16'hFFF8
`define SGP_IDX_PINS      16'hFFF9

`define SGP_ADDR_W        18
`define SGP_RST_LATCH     8'h00
`define SGP_RST_DIR       8'h00
`define SGP_RST_PIN       8'h00
`define SGP_RST_OE_N      8'hFF
`define SGP_DIR_READBACK  8'hFF
`define SGP_UNMAPPED      32'h00000000

// segment select: the top two bits decide gpio or segment use
`define SGP_SEL_HI        3
`define SGP_SEL_LO        2
`define SGP_SEL_GPIO      2'b00
`define SGP_SEG_BASE      17

// status word fields
`define SGP_STAT_OE_LSB   0
`define SGP_STAT_SEL_LSB  8
`define SGP_STAT_MODE_LSB 12

`endif

// ### pkg/sgp_pkg.sv
// sgp_pkg: types of the segment-shared gpio port.
// assumes sgp_map.svh for all numeric constants except the mode and bus codes set here.
package sgp_pkg;

    typedef enum logic [5:0] {
        SGP_MODE_ACTIVE    = 6'h01,
        SGP_MODE_SUBACTIVE = 6'h02,
        SGP_MODE_SLEEP     = 6'h04,
        SGP_MODE_SUBSLEEP  = 6'h08,
        SGP_MODE_WATCH     = 6'h10,
        SGP_MODE_STANDBY   = 6'h20
    } sgp_mode_e;

    typedef enum logic [1:0] {
        SGP_BUS_IDLE = 2'h1,
        SGP_BUS_ACK  = 2'h2
    } sgp_bus_e;

    typedef struct packed {
        sgp_bus_e    st;
        logic [7:0]  latch;
        logic [7:0]  dir;
        logic [31:0] rdata;
    } sgp_port_s;

    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
    } sgp_sync_s;

    typedef struct packed {
        logic [7:0] pin;
        logic [7:0] oe_n;
    } sgp_drive_s;

endpackage : sgp_pkg

// ### verilog/sgp_sync.sv
// sgp_sync: two-flop synchroniser for the eight port pin inputs.
// assumes pins are asynchronous to mclk_i.
`timescale 1ns/1ps
module sgp_sync
    import sgp_pkg::*;
(
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    // pins in, levels out
    input  wire logic [7:0] async_i,
    output logic      [7:0] sync_o
);
    sgp_sync_s q;
    sgp_sync_s d;

    always_comb begin
        d    = q;
        d.s1 = async_i;
        d.s2 = q.s1;
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync_o = q.s2;
endmodule : sgp_sync

// ### verilog/sgp_drive.sv
// sgp_drive: registered pin output stage with power-mode behaviour.
// assumes mode_i comes from logic on mclk_i; enable outputs are active low.
`timescale 1ns/1ps
`include "sgp_map.svh"
module sgp_drive
    import sgp_pkg::*;
(
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    // wanted pin state
    input  wire logic [5:0] mode_i,
    input  wire logic [7:0] out_want_i,
    input  wire logic [7:0] drv_want_i,
    // pins
    output logic      [7:0] pin_o,
    output logic      [7:0] pin_oe_n_o
);
    sgp_drive_s q;
    sgp_drive_s d;

    always_comb begin
        d = q;
        case (mode_i)
            SGP_MODE_ACTIVE, SGP_MODE_SUBACTIVE: begin
                d.pin  = out_want_i;    // (R11)
                d.oe_n = ~drv_want_i;
            end
            SGP_MODE_SLEEP, SGP_MODE_SUBSLEEP, SGP_MODE_WATCH: begin
                d = q;                  // (R11)
            end
            SGP_MODE_STANDBY: begin
                d.oe_n = `SGP_RST_OE_N; // (R10)
            end
            default: begin
                // unknown mode code: float rather than guess
                d.oe_n = `SGP_RST_OE_N;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            q.pin  <= `SGP_RST_PIN;
            q.oe_n <= `SGP_RST_OE_N;    // (R10)
        end else begin
            q <= d;
        end
    end

    assign pin_o      = q.pin;
    // reset floats the pins at once, not only from the first edge
    assign pin_oe_n_o = q.oe_n | {8{sys_rst_i}}; // (R10)
endmodule : sgp_drive

// ### verilog/sgp_port.sv
// sgp_port: eight-bit gpio port sharing its pins with lcd segment outputs, avalon-mm slave.
// assumes the lcd controller and power controller run on mclk_i; pins are asynchronous.
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
`include "sgp_map.svh"
module sgp_port
    import sgp_pkg::*;
(
    // clock and reset
    input  wire logic                     mclk_i,
    input  wire logic                     sys_rst_i,
    // avalon-mm slave
    input  wire logic [`SGP_ADDR_W-1:0]   avs_address_i,
    input  wire logic                     avs_read_i,
    input  wire logic                     avs_write_i,
    input  wire logic [31:0]              avs_writedata_i,
    input  wire logic [3:0]               avs_byteenable_i,
    output logic      [31:0]              avs_readdata_o,
    output logic                          avs_waitrequest_o,
    // lcd controller
    input  wire logic [3:0]               segment_select_field_i,
    input  wire logic [7:0]               lcd_segment_output_i,
    // power mode, one-hot
    input  wire logic [5:0]               mode_i,
    // port pins
    input  wire logic [7:0]               port_pin_i,
    output logic      [7:0]               port_pin_o,
    output logic      [7:0]               port_pin_oe_n_o
);
    localparam sgp_port_s RST_STATE = '{
        st:    SGP_BUS_IDLE,
        latch: `SGP_RST_LATCH,
        dir:   `SGP_RST_DIR,
        rdata: `SGP_UNMAPPED
    };

    sgp_port_s  q;
    sgp_port_s  d;
    logic [7:0] pin_lvl;
    logic [7:0] out_want;
    logic [7:0] drv_want;
    logic       gpio_use;
    logic       req;

    function automatic logic word_hit(input logic [`SGP_ADDR_W-1:0] addr, input logic [15:0] idx);
        word_hit = (addr[`SGP_ADDR_W-1:2] == idx);
    endfunction : word_hit

    function automatic logic sel_is_gpio(input logic [3:0] sel);
        sel_is_gpio = (sel[`SGP_SEL_HI:`SGP_SEL_LO] == `SGP_SEL_GPIO);
    endfunction : sel_is_gpio

    // per bit: latch where output, pin level where input
    function automatic logic [7:0] read_mix(input logic [7:0] dir, input logic [7:0] latch,
                                            input logic [7:0] pin);
        read_mix = (dir & latch) | (~dir & pin);
    endfunction : read_mix

    function automatic logic [31:0] read_word(input logic [`SGP_ADDR_W-1:0] addr,
                                              input sgp_port_s s, input logic [7:0] pin,
                                              input logic [7:0] oe_n, input logic [3:0] sel,
                                              input logic [5:0] mode);
        logic [31:0] w;
        w = `SGP_UNMAPPED;
        if (word_hit(addr, `SGP_IDX_LATCH)) begin
            w[7:0] = read_mix(s.dir, s.latch, pin); // (R2) (R3)
        end else if (word_hit(addr, `SGP_IDX_DIR)) begin
            w[7:0] = `SGP_DIR_READBACK; // (R7)
        end else if (word_hit(addr, `SGP_IDX_STAT)) begin
            w[`SGP_STAT_OE_LSB +: 8]   = ~oe_n;
            w[`SGP_STAT_SEL_LSB +: 4]  = sel;
            w[`SGP_STAT_MODE_LSB +: 6] = mode;
        end else if (word_hit(addr, `SGP_IDX_PINS)) begin
            w[7:0] = pin;
        end
        read_word = w;
    endfunction : read_word

    // pins pass two flops before anything reads them
    sgp_sync u_sync (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (port_pin_i),
        .sync_o    (pin_lvl)
    );

    assign gpio_use = sel_is_gpio(segment_select_field_i); // (R9)

    // segment use overrides direction and latch entirely
    always_comb begin
        if (gpio_use) begin
            out_want = q.latch; // (R6) (R5)
            drv_want = q.dir;   // (R5)
        end else begin
            out_want = lcd_segment_output_i; // (R9)
            drv_want = 8'hFF;                // (R9)
        end
    end

    sgp_drive u_drive (
        .mclk_i     (mclk_i),
        .sys_rst_i  (sys_rst_i),
        .mode_i     (mode_i),
        .out_want_i (out_want),
        .drv_want_i (drv_want),
        .pin_o      (port_pin_o),
        .pin_oe_n_o (port_pin_oe_n_o)
    );

    // bus: one wait cycle on every access, so read data is always from a flop
    assign req               = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req & (q.st != SGP_BUS_ACK);
    assign avs_readdata_o    = q.rdata;

    always_comb begin
        d = q;
        case (q.st)
            SGP_BUS_IDLE: begin
                if (req) begin
                    d.st = SGP_BUS_ACK;
                    if (avs_read_i) begin
                        d.rdata = read_word(avs_address_i, q, pin_lvl, port_pin_oe_n_o,
                                            segment_select_field_i, mode_i);
                    end
                end
            end
            SGP_BUS_ACK: begin
                d.st = SGP_BUS_IDLE;
                // only lane 0 carries data; a write without it changes nothing
                if (avs_write_i && avs_byteenable_i[0]) begin
                    if (word_hit(avs_address_i, `SGP_IDX_LATCH)) begin
                        d.latch = avs_writedata_i[7:0]; // (R1) (R12)
                    end
                    if (word_hit(avs_address_i, `SGP_IDX_DIR)) begin
                        d.dir = avs_writedata_i[7:0];   // (R5)
                    end
                end
            end
            default: begin
                d.st = SGP_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            q <= RST_STATE; // (R4) (R8)
        end else begin
            q <= d;
        end
    end
endmodule : sgp_port

// ### sim/sgp_port_chk.sv
// sgp_port_chk: pin and bus answer assertions for sgp_port.
// assumes one clock and a synchronous reset; bound below.
`timescale 1ns/1ps
`include "sgp_map.svh"
module sgp_port_chk (
    // clock, reset, bus
    input wire logic                   mclk_i,
    input wire logic                   sys_rst_i,
    input wire logic [`SGP_ADDR_W-1:0] avs_address_i,
    input wire logic                   avs_read_i,
    input wire logic                   avs_write_i,
    input wire logic [31:0]            avs_writedata_i,
    input wire logic [3:0]             avs_byteenable_i,
    input wire logic [31:0]            avs_readdata_o,
    input wire logic                   avs_waitrequest_o,
    // lcd and power
    input wire logic [3:0]             segment_select_field_i,
    input wire logic [7:0]             lcd_segment_output_i,
    input wire logic [5:0]             mode_i,
    // pins
    input wire logic [7:0]             port_pin_o,
    input wire logic [7:0]             port_pin_oe_n_o
);
    wire run = mode_i == 6'h01 || mode_i == 6'h02;
    wire lcd_segment_output = segment_select_field_i[3:2] != 2'h0;
    wire ack = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // must hold while reset is high, so not disabled by it
    rst_float_a: assert property (disable iff (1'h0) sys_rst_i |-> port_pin_oe_n_o == 8'hFF)
        else $error("pins driven in reset");
    seg_drive_a: assert property (lcd_segment_output && run |=> port_pin_o == $past(lcd_segment_output_i) && port_pin_oe_n_o == 8'h00)
        else $error("segment value not on pins");
    standby_float_a: assert property (mode_i == 6'h20 |=> port_pin_oe_n_o == 8'hFF)
        else $error("pins driven in standby");
    hold_pins_a: assert property (mode_i inside {6'h04, 6'h08, 6'h10} |=> $stable(port_pin_o) && $stable(port_pin_oe_n_o))
        else $error("pins moved in hold mode");
    dir_ones_a: assert property (ack && avs_read_i && avs_address_i == 18'h3FFA8 |-> avs_readdata_o == 32'h000000FF)
        else $error("direction read not all ones");
    latch_width_a: assert property (ack && avs_read_i && avs_address_i == 18'h3FF68 |-> avs_readdata_o[31:8] == 24'h0)
        else $error("latch read wider than eight bits");
    wr_drive_a: assert property (ack && avs_write_i && avs_byteenable_i[0] && avs_address_i == 18'h3FF68 && run && !lcd_segment_output
        |-> ##2 ((port_pin_o ^ $past(avs_writedata_i[7:0], 2)) & ~port_pin_oe_n_o) == 8'h00)
        else $error("driven pins differ from latch");
    rst_input_a: assert property ($fell(sys_rst_i) && run && !lcd_segment_output |=> port_pin_oe_n_o == 8'hFF)
        else $error("pin driven after reset");
    cover property (lcd_segment_output && run);
    cover property (mode_i == 6'h20);
    cover property (ack && avs_write_i);
endmodule : sgp_port_chk

bind sgp_port sgp_port_chk i_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .segment_select_field_i(segment_select_field_i), .lcd_segment_output_i(lcd_segment_output_i),
    .mode_i(mode_i), .port_pin_o(port_pin_o), .port_pin_oe_n_o(port_pin_oe_n_o));

// ### sim/sgp_port_tb_top.sv
// sgp_port_tb_top: register and pin sequences for sgp_port.
// assumes the checker binds itself; the bench drives the pins.
`timescale 1ns/1ps
`include "sgp_map.svh"
module sgp_port_tb_top
    import sgp_pkg::*;
;
    logic        mclk_i = 1'h0, sys_rst_i = 1'h1, avs_read_i = 1'h0, avs_write_i = 1'h0, avs_waitrequest_o;
    logic [17:0] avs_address_i = 18'h0;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
    logic [3:0]  avs_byteenable_i = 4'hF, segment_select_field_i = 4'h0;
    logic [7:0]  lcd_segment_output_i = 8'h96, port_pin_i = 8'h00, port_pin_o, port_pin_oe_n_o;
    logic [5:0]  mode_i = 6'h01;
    logic [3:0]  sels [5] = '{4'h4, 4'h7, 4'h8, 4'hF, 4'h3};
    int          bad_count = 0, checks_done = 0, cyc = 0;
    localparam logic [17:0] LAT = 18'h3FF68, DIR = 18'h3FFA8;

    always #5 mclk_i = ~mclk_i;

    sgp_port i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .segment_select_field_i(segment_select_field_i), .lcd_segment_output_i(lcd_segment_output_i),
        .mode_i(mode_i), .port_pin_i(port_pin_i), .port_pin_o(port_pin_o), .port_pin_oe_n_o(port_pin_oe_n_o));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // entered just after a rising edge; held until waitrequest is seen low
    task automatic bus(input logic w, input logic [17:0] a, input logic [7:0] d);
        avs_address_i   <= a;
        avs_writedata_i <= {24'h0, d};
        avs_write_i     <= w;
        avs_read_i      <= !w;
        // waitrequest and read data are both taken at the rising edge that ends the wait
        do @(posedge mclk_i); while (avs_waitrequest_o !== 1'h0);
        q = avs_readdata_o;
        avs_write_i <= 1'h0;
        avs_read_i  <= 1'h0;
        @(posedge mclk_i);
    endtask : bus

    task automatic rd(input logic [17:0] a, input logic [31:0] e);
        bus(1'h0, a, 8'h00);
        chk(q, e);
    endtask : rd

    // undriven pins keep a stale value, so only driven bits are compared
    task automatic pins(input logic [7:0] o, input logic [7:0] oe);
        repeat (2) @(posedge mclk_i);
        @(negedge mclk_i);
        chk({16'h0, port_pin_o & ~oe, port_pin_oe_n_o}, {16'h0, o & ~oe, oe});
        @(posedge mclk_i);
    endtask : pins

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test

    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            end_of_test();
        end
    end

    initial begin
        repeat (20) @(posedge mclk_i);
        sys_rst_i  <= 1'h0;
        port_pin_i <= 8'hA5;
        pins(8'h00, 8'hFF);
        rd(LAT, 32'h000000A5);
        rd(DIR, 32'h000000FF);
        bus(1'h1, LAT, 8'h3C);
        pins(8'h00, 8'hFF);
        bus(1'h1, DIR, 8'hF0);
        port_pin_i <= 8'h5A;
        pins(8'h30, 8'h0F);
        rd(LAT, 32'h0000003A);
        $display("latch and direction test done");
        foreach (sels[i]) begin
            segment_select_field_i <= sels[i];
            if (sels[i][3:2] != 2'h0) pins(8'h96, 8'h00);
            else pins(8'h30, 8'h0F);
        end
        $display("segment test done");
        foreach (sels[i]) begin
            if (i < 3) begin
                mode_i <= 6'h04 << i;
                bus(1'h1, LAT, 8'hC0);
                pins(8'h30, 8'h0F);
            end
        end
        mode_i <= SGP_MODE_ACTIVE;
        pins(8'hC0, 8'h0F);
        mode_i <= SGP_MODE_STANDBY;
        pins(8'h00, 8'hFF);
        mode_i <= SGP_MODE_SUBACTIVE;
        pins(8'hC0, 8'h0F);
        rd(18'h00000, 32'h0);
        $display("power mode test done");
        sys_rst_i <= 1'h1;
        repeat (3) @(posedge mclk_i);
        sys_rst_i <= 1'h0;
        pins(8'h00, 8'hFF);
        bus(1'h1, DIR, 8'hFF);
        pins(8'h00, 8'h00);
        rd(LAT, 32'h00000000);
        rd(18'h3FFE0, 32'h000023FF);
        rd(18'h3FFE4, 32'h0000005A);
        $display("second reset test done");
        end_of_test();
    end
endmodule : sgp_port_tb_top
